// file: rtl/erpm_pkg.sv
// Purpose: Constants and carrier types for the evaluator port demultiplexer.
// Assumes: One 10 MHz clock; device pins sampled synchronously.
// Notes:   Port numbers and widths follow the device's port scheme.
package erpm_pkg;

    // ------------------------------------------------------------
    // Widths and port numbers
    // ------------------------------------------------------------
    localparam int unsigned PC_W       = 12;
    localparam int unsigned NIB_W      = 4;
    localparam int unsigned SEL_W      = 8;
    localparam int unsigned DIGIT_W    = 5;
    localparam int unsigned SEG_W      = 8;
    localparam logic [2:0]  PORT_IN0   = 3'h0;
    localparam logic [2:0]  PORT_OUT1  = 3'h1;
    localparam logic [2:0]  PORT_IO2   = 3'h2;
    localparam logic [2:0]  PORT_IO3   = 3'h3;
    localparam logic [2:0]  PORT_IO4   = 3'h4;
    localparam logic [2:0]  PORT_DIG5  = 3'h5;
    localparam logic [2:0]  PORT_SEG6  = 3'h6;
    localparam logic [2:0]  PORT_OUT7  = 3'h7;
    localparam logic [3:0]  NIB_RST    = 4'h0;
    localparam logic [4:0]  DIGIT_RST  = 5'h00;
    localparam logic [7:0]  SEG_RST    = 8'h00;
    localparam logic [11:0] ADDR_RST   = 12'h000;

    // ------------------------------------------------------------
    // Divider for the emulated 100 kHz crystal option
    // ------------------------------------------------------------
    localparam int unsigned DIV_STAGES = 14;
    localparam logic [13:0] DIV_TERM   = 14'h30D4;
    localparam logic [13:0] DIV_RST    = 14'h0000;
    localparam logic [3:0]  BASE_HALF  = 4'h4;

    // ------------------------------------------------------------
    // Carrier types
    // ------------------------------------------------------------
    typedef struct packed {
        logic [SEL_W-1:0] port_strobe;
        logic             sample_phase;
        logic             write_phase;
        logic             init_pulse;
    } erpm_strobe_s;

    typedef struct packed {
        logic [NIB_W-1:0] port1;
        logic [NIB_W-1:0] port2;
        logic [NIB_W-1:0] port3;
        logic [NIB_W-1:0] port4;
        logic [NIB_W-1:0] port7;
    } erpm_ports_s;

endpackage

// file: rtl/erpm_host.sv
// Purpose: Board logic around the evaluator: ROM address demux, port
//          registers, port input mux, display decode and clock divider.
// Assumes: All device pins are synchronous to i_ref_clk.
// Notes:   Port registers capture at the trailing edge of strobe and write phase.
`timescale 1ns/1ps

module erpm_host
    import erpm_pkg::*;
(
    // Clock and reset
    input  wire logic              i_ref_clk,
    input  wire logic              i_rst_b,
    // Host options
    input  wire logic              i_port0_output_only,
    input  wire logic              i_xtal100k_mode,
    // Device address and data pins
    input  wire logic [7:0]        i_addr_high,
    input  wire logic [NIB_W-1:0]  i_addr_low_dataout,
    output logic      [NIB_W-1:0]  o_code_low_datain,
    input  wire logic [NIB_W-1:0]  i_port0_pins,
    // Device strobes and status
    input  wire erpm_strobe_s      i_strobe,
    input  wire logic              i_direction_flag_out,
    output logic                   o_port0_direction_in,
    output logic                   o_base_clock_in,
    // ROM side
    output logic      [PC_W-1:0]   o_rom_addr,
    input  wire logic [7:0]        i_rom_data,
    // Raw inputs to condition
    input  wire logic              i_raw_reset,
    input  wire logic              i_raw_int,
    input  wire logic              i_raw_shaped,
    output logic                   o_reset_in,
    output logic                   o_int_in,
    output logic                   o_shaped_input_bit,
    // External ports
    input  wire logic [NIB_W-1:0]  i_port_in0,
    input  wire logic [NIB_W-1:0]  i_port_in3,
    output erpm_ports_s            o_ports,
    output logic [DIGIT_W-1:0]     o_digit_drive,
    output logic [SEG_W-1:0]       o_segment_drive,
    output logic                   o_timing_tap
);

    // ------------------------------------------------------------
    // Functions
    // ------------------------------------------------------------
    function automatic logic [DIGIT_W-1:0] digit_decode(input logic [3:0] v);
        logic [DIGIT_W-1:0] r;
        r = DIGIT_RST;
        if (v >= 4'h1 && v <= 4'h5) begin
            r = DIGIT_W'(5'h01 << (v - 4'h1));
        end
        return r;
    endfunction

    function automatic logic [SEG_W-1:0] seg_lookup(input logic [3:0] a);
        logic [SEG_W-1:0] r;
        r = SEG_RST;
        unique case (a)
            4'h0: r = 8'hFC;
            4'h1: r = 8'h60;
            4'h2: r = 8'hDA;
            4'h3: r = 8'hF2;
            4'h4: r = 8'h66;
            4'h5: r = 8'hB6;
            4'h6: r = 8'hBE;
            4'h7: r = 8'hE4;
            4'h8: r = 8'hFE;
            4'h9: r = 8'hF6;
            4'hA: r = 8'hFD;
            4'hB: r = 8'h00;
            4'hC: r = 8'h02;
            4'hD: r = 8'hCE;
            4'hE: r = 8'h9E;
            4'hF: r = 8'h8E;
        endcase
        return r;
    endfunction

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    logic [SEL_W-1:0]  wr_win_ff,   nxt_wr_win;
    erpm_ports_s       ports_ff,    nxt_ports;
    logic [3:0]        dig_ff,      nxt_dig;
    logic [3:0]        seg_ff,      nxt_seg;
    logic [DIGIT_W-1:0] digit_ff,   nxt_digit;
    logic [SEG_W-1:0]  segment_ff,  nxt_segment;
    logic [NIB_W-1:0]  dout_ff,     nxt_dout;
    logic [NIB_W-1:0]  din_ff,      nxt_din;
    logic [PC_W-1:0]   addr_ff,     nxt_addr;
    logic              dir_ff,      nxt_dir;
    logic [2:0]        shp_ff,      nxt_shp;
    logic              rst_ff,      nxt_rst;
    logic              int_ff,      nxt_int;
    logic [3:0]        bdiv_ff,     nxt_bdiv;
    logic              bclk_ff,     nxt_bclk;
    logic [13:0]       div_ff,      nxt_div;
    logic              tap_ff,      nxt_tap;
    logic [SEL_W-1:0]  wr_now;
    logic              any_sel;

    // ------------------------------------------------------------
    // Port capture and address demultiplexing
    // ------------------------------------------------------------
    always_comb begin
        wr_now  = i_strobe.write_phase ? i_strobe.port_strobe : '0;
        any_sel = |i_strobe.port_strobe;
        nxt_wr_win  = wr_now;
        nxt_dout    = wr_now != '0 ? i_addr_low_dataout : dout_ff;
        nxt_ports   = ports_ff;
        nxt_dig     = dig_ff;
        nxt_seg     = seg_ff;
        nxt_addr    = addr_ff;
        // The held nibble is committed once the window closes, so a
        // value still settling mid-window never reaches the register.
        if (wr_win_ff[PORT_OUT1] && !wr_now[PORT_OUT1]) nxt_ports.port1 = dout_ff;
        if (wr_win_ff[PORT_IO2]  && !wr_now[PORT_IO2])  nxt_ports.port2 = dout_ff;
        if (wr_win_ff[PORT_IO3]  && !wr_now[PORT_IO3])  nxt_ports.port3 = dout_ff;
        if (wr_win_ff[PORT_IO4]  && !wr_now[PORT_IO4])  nxt_ports.port4 = dout_ff;
        if (wr_win_ff[PORT_OUT7] && !wr_now[PORT_OUT7]) nxt_ports.port7 = dout_ff;
        if (wr_win_ff[PORT_DIG5] && !wr_now[PORT_DIG5]) nxt_dig = dout_ff;
        if (wr_win_ff[PORT_SEG6] && !wr_now[PORT_SEG6]) nxt_seg = dout_ff;
        if (i_strobe.init_pulse) begin
            nxt_ports = '0;
            nxt_dig   = NIB_RST;
            nxt_seg   = NIB_RST;
            nxt_dout  = NIB_RST;
        end
        if (!any_sel) begin
            nxt_addr = {i_addr_high, i_addr_low_dataout};
        end
        nxt_digit   = digit_decode(dig_ff);
        nxt_segment = seg_lookup(seg_ff);
        nxt_dir     = i_port0_output_only ? 1'b1 : i_direction_flag_out;
    end

    // ------------------------------------------------------------
    // Input data multiplexer
    // ------------------------------------------------------------
    always_comb begin
        nxt_din = i_rom_data[NIB_W-1:0];
        if (i_strobe.sample_phase) begin
            unique case (1'b1)
                i_strobe.port_strobe[PORT_IN0]: nxt_din = dir_ff ? NIB_RST : i_port_in0;
                i_strobe.port_strobe[PORT_IO2]: nxt_din = ports_ff.port2;
                i_strobe.port_strobe[PORT_IO3]: nxt_din = i_port_in3;
                i_strobe.port_strobe[PORT_IO4]: nxt_din = ports_ff.port4;
                default:                        nxt_din = i_rom_data[NIB_W-1:0];
            endcase
        end
    end

    // ------------------------------------------------------------
    // Conditioning and clocks
    // ------------------------------------------------------------
    always_comb begin
        nxt_shp  = {shp_ff[1:0], i_raw_shaped};
        nxt_rst  = i_raw_reset;
        nxt_int  = i_raw_int;
        nxt_bdiv = bdiv_ff + 4'h1;
        nxt_bclk = bclk_ff;
        if (bdiv_ff == BASE_HALF) begin
            nxt_bdiv = 4'h0;
            nxt_bclk = ~bclk_ff;
        end
        nxt_div = div_ff;
        nxt_tap = 1'b0;
        if (bdiv_ff == BASE_HALF && !bclk_ff) begin
            nxt_div = div_ff + 14'h0001;
            // Greater-or-equal so that a mode switch made while the free count sits
            // above the terminal value still folds back instead of wrapping.
            if (i_xtal100k_mode && div_ff >= DIV_TERM - 14'h0001) begin
                nxt_div = DIV_RST;
                nxt_tap = 1'b1;
            end else if (!i_xtal100k_mode) begin
                nxt_tap = div_ff[0];
            end
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            wr_win_ff  <= '0;
            ports_ff   <= '0;
            dig_ff     <= NIB_RST;
            seg_ff     <= NIB_RST;
            digit_ff   <= DIGIT_RST;
            segment_ff <= SEG_RST;
            dout_ff    <= NIB_RST;
            din_ff     <= NIB_RST;
            addr_ff    <= ADDR_RST;
            dir_ff     <= 1'b0;
            shp_ff     <= 3'h0;
            rst_ff     <= 1'b0;
            int_ff     <= 1'b0;
            bdiv_ff    <= 4'h0;
            bclk_ff    <= 1'b0;
            div_ff     <= DIV_RST;
            tap_ff     <= 1'b0;
        end else begin
            wr_win_ff  <= nxt_wr_win;
            ports_ff   <= nxt_ports;
            dig_ff     <= nxt_dig;
            seg_ff     <= nxt_seg;
            digit_ff   <= nxt_digit;
            segment_ff <= nxt_segment;
            dout_ff    <= nxt_dout;
            din_ff     <= nxt_din;
            addr_ff    <= nxt_addr;
            dir_ff     <= nxt_dir;
            shp_ff     <= nxt_shp;
            rst_ff     <= nxt_rst;
            int_ff     <= nxt_int;
            bdiv_ff    <= nxt_bdiv;
            bclk_ff    <= nxt_bclk;
            div_ff     <= nxt_div;
            tap_ff     <= nxt_tap;
        end
    end

    assign o_code_low_datain    = din_ff;
    assign o_port0_direction_in = dir_ff;
    assign o_base_clock_in      = bclk_ff;
    assign o_rom_addr           = addr_ff;
    assign o_reset_in           = rst_ff;
    assign o_int_in             = int_ff;
    assign o_shaped_input_bit   = shp_ff[2];
    assign o_ports              = ports_ff;
    assign o_digit_drive        = digit_ff;
    assign o_segment_drive      = segment_ff;
    assign o_timing_tap         = tap_ff;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    property p_init_clear;
        @(posedge i_ref_clk) disable iff (!i_rst_b)
        i_strobe.init_pulse |=> (ports_ff == '0);
    endproperty
    a_init_clear: assert property (p_init_clear) else $error("port registers not cleared");

    property p_digit;
        @(posedge i_ref_clk) disable iff (!i_rst_b)
        ##1 (digit_ff == digit_decode($past(dig_ff)));
    endproperty
    a_digit: assert property (p_digit) else $error("digit decode wrong");

    property p_digit_onehot;
        @(posedge i_ref_clk) disable iff (!i_rst_b)
        $countones(o_digit_drive) <= 1;
    endproperty
    a_digit_onehot: assert property (p_digit_onehot) else $error("more than one digit line");

    sequence s_win_p2;
        i_strobe.write_phase && i_strobe.port_strobe[PORT_IO2] && !i_strobe.init_pulse;
    endsequence
    sequence s_close_p2;
        !(i_strobe.write_phase && i_strobe.port_strobe[PORT_IO2]) && !i_strobe.init_pulse;
    endsequence
    property p_port2_capture;
        @(posedge i_ref_clk) disable iff (!i_rst_b)
        (s_win_p2 ##1 s_close_p2) |=> (ports_ff.port2 == $past(i_addr_low_dataout, 2));
    endproperty
    a_port2_capture: assert property (p_port2_capture) else $error("port 2 capture wrong");

    property p_sample_p4;
        @(posedge i_ref_clk) disable iff (!i_rst_b)
        (i_strobe.sample_phase && i_strobe.port_strobe == 8'h10) |=> (din_ff == $past(ports_ff.port4));
    endproperty
    a_sample_p4: assert property (p_sample_p4) else $error("port 4 readback wrong");

    property p_rom_pass;
        @(posedge i_ref_clk) disable iff (!i_rst_b)
        !i_strobe.sample_phase |=> (din_ff == $past(i_rom_data[3:0]));
    endproperty
    a_rom_pass: assert property (p_rom_pass) else $error("ROM nibble not passed");

    property p_addr;
        @(posedge i_ref_clk) disable iff (!i_rst_b)
        (i_strobe.port_strobe == '0) |=> (o_rom_addr == $past({i_addr_high, i_addr_low_dataout}));
    endproperty
    a_addr: assert property (p_addr) else $error("ROM address not latched");

    property p_dir;
        @(posedge i_ref_clk) disable iff (!i_rst_b)
        i_port0_output_only |=> o_port0_direction_in;
    endproperty
    a_dir: assert property (p_dir) else $error("direction not forced to output");

    property p_div_term;
        @(posedge i_ref_clk) disable iff (!i_rst_b)
        (i_xtal100k_mode && div_ff < DIV_TERM) |=> (div_ff < DIV_TERM);
    endproperty
    a_div_term: assert property (p_div_term) else $error("divider passed terminal count");

endmodule

// file: tb/erpm_dev_model.sv
// Purpose: Behavioural model of the evaluator chip as seen from its pins.
// Assumes: The bench calls these tasks; pins change just after a falling edge.
// Notes:   Low address pins show the program counter outside write windows.
`timescale 1ns/1ps
module erpm_dev_model
    import erpm_pkg::*;
(
    // Clock
    input  wire logic             i_ref_clk,
    // Device pins
    output logic      [7:0]       o_addr_high,
    output logic      [NIB_W-1:0] o_addr_low_dataout,
    output erpm_strobe_s          o_strobe,
    output logic                  o_direction_flag_out,
    input  wire logic [NIB_W-1:0] i_code_low_datain
);
    // ------------------------------------------------------------
    // Pin tasks
    // ------------------------------------------------------------
    logic [PC_W-1:0] pc_ff;

    initial begin
        pc_ff = ADDR_RST;
        o_addr_high = 8'h00;
        o_addr_low_dataout = 4'h0;
        o_strobe = '0;
        o_direction_flag_out = 1'b0;
    end

    task automatic fetch(input logic [PC_W-1:0] pc);
        @(negedge i_ref_clk);
        pc_ff = pc;
        o_addr_high = pc[11:4];
        o_addr_low_dataout = pc[3:0];
    endtask

    // The nibble changes inside the window, so a host that captures early is caught.
    task automatic port_write(input logic [2:0] port, input logic [NIB_W-1:0] d0, input logic [NIB_W-1:0] d1);
        @(negedge i_ref_clk);
        o_strobe.port_strobe = 8'h01 << port;
        o_strobe.write_phase = 1'b1;
        o_addr_low_dataout = d0;
        @(negedge i_ref_clk);
        o_addr_low_dataout = d1;
        @(negedge i_ref_clk);
        o_strobe = '0;
        o_addr_low_dataout = pc_ff[3:0];
    endtask

    task automatic port_read(input logic [2:0] port, output logic [NIB_W-1:0] d);
        @(negedge i_ref_clk);
        o_strobe.port_strobe = 8'h01 << port;
        o_strobe.sample_phase = 1'b1;
        @(negedge i_ref_clk);
        d = i_code_low_datain;
        o_strobe = '0;
    endtask

    task automatic init_pulse();
        @(negedge i_ref_clk);
        o_strobe.init_pulse = 1'b1;
        @(negedge i_ref_clk);
        o_strobe.init_pulse = 1'b0;
    endtask

    task automatic set_flag(input logic v);
        @(negedge i_ref_clk);
        o_direction_flag_out = v;
    endtask
endmodule

// file: tb/evaluator_rom_port_mux_bench.sv
// Purpose: Self-checking bench for the evaluator host logic.
// Assumes: The device model and the bench drive inputs at the falling edge.
// Notes:   Expected values come from the port scheme, never from the design.
`timescale 1ns/1ps
module evaluator_rom_port_mux_bench
    import erpm_pkg::*;
();
    // ------------------------------------------------------------
    // Signals and instances
    // ------------------------------------------------------------
    localparam logic [7:0]      SEG_TAB [16] = '{8'hFC, 8'h60, 8'hDA, 8'hF2, 8'h66, 8'hB6, 8'hBE, 8'hE4,
                                                 8'hFE, 8'hF6, 8'hFD, 8'h00, 8'h02, 8'hCE, 8'h9E, 8'h8E};
    localparam logic [2:0]      WR_PORT [5]  = '{PORT_OUT1, PORT_IO2, PORT_IO3, PORT_IO4, PORT_OUT7};
    localparam logic [PC_W-1:0] PC_LIST [4]  = '{12'hFFF, 12'h000, 12'h5A3, 12'hA5C};
    logic                       ref_clk;
    logic                       rst_b;
    logic                       out_only;
    logic                       xtal_mode;
    logic [7:0]                 addr_high;
    logic [NIB_W-1:0]           addr_low;
    logic [NIB_W-1:0]           code_low;
    erpm_strobe_s               strobe;
    logic                       dflag;
    logic                       dir_in;
    logic                       base_clk;
    logic [PC_W-1:0]            rom_addr;
    logic [7:0]                 rom_data;
    logic                       raw_reset;
    logic                       raw_int;
    logic                       raw_shaped;
    logic                       reset_in;
    logic                       int_in;
    logic                       shaped;
    logic [NIB_W-1:0]           port_in0;
    logic [NIB_W-1:0]           port_in3;
    erpm_ports_s                ports;
    logic [DIGIT_W-1:0]         digit;
    logic [SEG_W-1:0]           seg;
    logic                       tap;
    logic                       base_q = 1'b0;
    logic                       tap_q = 1'b0;
    logic                       tap_wide = 1'b0;
    int                         base_cnt, base_per, tap_cnt, tap_per, cycles, bad_count, tests_run;

    // The program memory answers from the latched address with a fixed pattern.
    assign rom_data = rom_addr[7:0] ^ 8'hA5;

    erpm_host i_dut (.i_ref_clk(ref_clk), .i_rst_b(rst_b), .i_port0_output_only(out_only),
        .i_xtal100k_mode(xtal_mode), .i_addr_high(addr_high), .i_addr_low_dataout(addr_low),
        .o_code_low_datain(code_low), .i_port0_pins(4'h0), .i_strobe(strobe),
        .i_direction_flag_out(dflag), .o_port0_direction_in(dir_in), .o_base_clock_in(base_clk),
        .o_rom_addr(rom_addr), .i_rom_data(rom_data), .i_raw_reset(raw_reset), .i_raw_int(raw_int),
        .i_raw_shaped(raw_shaped), .o_reset_in(reset_in), .o_int_in(int_in), .o_shaped_input_bit(shaped),
        .i_port_in0(port_in0), .i_port_in3(port_in3), .o_ports(ports), .o_digit_drive(digit),
        .o_segment_drive(seg), .o_timing_tap(tap));

    erpm_dev_model i_dev (.i_ref_clk(ref_clk), .o_addr_high(addr_high), .o_addr_low_dataout(addr_low),
        .o_strobe(strobe), .o_direction_flag_out(dflag), .i_code_low_datain(code_low));

    // ------------------------------------------------------------
    // Clock, edge measurement and run limit
    // ------------------------------------------------------------
    always #50 ref_clk = ~ref_clk;

    always @(posedge ref_clk) begin
        base_q <= base_clk;
        tap_q <= tap;
        base_cnt <= (base_clk && !base_q) ? 1 : base_cnt + 1;
        tap_cnt <= (tap && !tap_q) ? 1 : tap_cnt + 1;
        if (base_clk && !base_q) base_per <= base_cnt;
        if (tap && !tap_q) tap_per <= tap_cnt;
        if (tap && tap_q) tap_wide <= 1'b1;
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            bad_count = bad_count + 1;
            summarize();
        end
    end

    function automatic logic [3:0] port_reg(input logic [2:0] p);
        case (p)
            PORT_OUT1: return ports.port1;
            PORT_IO2:  return ports.port2;
            PORT_IO3:  return ports.port3;
            PORT_IO4:  return ports.port4;
            default:   return ports.port7;
        endcase
    endfunction

    task automatic check(input logic [19:0] seen, input logic [19:0] exp);
        tests_run = tests_run + 1;
        if (seen !== exp) begin
            bad_count = bad_count + 1;
            $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask

    task automatic summarize();
        $display("Comparisons %0d, mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------
    initial begin
        logic [NIB_W-1:0] v;
        ref_clk = 1'b0;
        rst_b = 1'b0;
        out_only = 1'b0;
        xtal_mode = 1'b0;
        raw_reset = 1'b0;
        raw_int = 1'b0;
        raw_shaped = 1'b0;
        port_in0 = 4'h9;
        port_in3 = 4'h6;
        repeat (20) @(posedge ref_clk);
        @(negedge ref_clk);
        check(20'(ports), 20'h00000);
        check({7'h00, digit, seg}, 20'h00000);
        rst_b = 1'b1;
        $display("Test reset done");
        for (int i = 0; i < 4; i++) begin
            i_dev.fetch(PC_LIST[i]);
            repeat (2) @(negedge ref_clk);
            check(20'(rom_addr), 20'(PC_LIST[i]));
            check(20'(code_low), 20'(PC_LIST[i][3:0] ^ 4'h5));
        end
        $display("Test fetch done");
        for (int i = 0; i < 5; i++) begin
            v = 4'hC ^ {1'b0, WR_PORT[i]};
            i_dev.port_write(WR_PORT[i], ~v, v);
            repeat (2) @(negedge ref_clk);
            check(20'(port_reg(WR_PORT[i])), 20'(v));
            check(20'(rom_addr), 20'h00A5C);
        end
        $display("Test port write done");
        i_dev.port_read(PORT_IO2, v);
        check(20'(v), 20'h0000E);
        i_dev.port_read(PORT_IO4, v);
        check(20'(v), 20'h00008);
        i_dev.port_read(PORT_IO3, v);
        check(20'(v), 20'h00006);
        i_dev.port_read(PORT_IN0, v);
        check(20'(v), 20'h00009);
        check(20'(dir_in), 20'h00000);
        i_dev.set_flag(1'b1);
        repeat (2) @(negedge ref_clk);
        check(20'(dir_in), 20'h00001);
        i_dev.port_read(PORT_IN0, v);
        check(20'(v), 20'h00000);
        i_dev.set_flag(1'b0);
        out_only = 1'b1;
        repeat (2) @(negedge ref_clk);
        check(20'(dir_in), 20'h00001);
        out_only = 1'b0;
        $display("Test port read done");
        for (int i = 0; i < 16; i++) begin
            i_dev.port_write(PORT_DIG5, ~i[3:0], i[3:0]);
            i_dev.port_write(PORT_SEG6, ~i[3:0], i[3:0]);
            repeat (4) @(negedge ref_clk);
            check(20'(digit), (i >= 1 && i <= 5) ? 20'h00001 << (i - 1) : 20'h00000);
            check(20'(seg), 20'(SEG_TAB[i]));
        end
        $display("Test display done");
        i_dev.port_write(PORT_DIG5, 4'h2, 4'h2);
        i_dev.init_pulse();
        repeat (4) @(negedge ref_clk);
        check(20'(ports), 20'h00000);
        check(20'(digit), 20'h00000);
        $display("Test init done");
        raw_reset = 1'b1;
        raw_int = 1'b1;
        raw_shaped = 1'b1;
        @(negedge ref_clk);
        check({18'h00000, reset_in, int_in}, 20'h00003);
        @(negedge ref_clk);
        check(20'(shaped), 20'h00000);
        @(negedge ref_clk);
        check(20'(shaped), 20'h00001);
        raw_reset = 1'b0;
        $display("Test conditioning done");
        repeat (60) @(negedge ref_clk);
        check(20'(base_per), 20'h0000A);
        check(20'(tap_per), 20'h00014);
        xtal_mode = 1'b1;
        repeat (26000) @(negedge ref_clk);
        // A full terminal period is far beyond the run limit, so the check is that no
        // early terminal pulse came while the divider was still short of its end count.
        check(20'(tap_cnt >= 26000), 20'h00001);
        check(20'(tap_wide), 20'h00000);
        $display("Test clocks done");
        summarize();
    end
endmodule
